/* File: src/lcio_top.sv */
// Four-channel line circuit I/O ports with an AHB-Lite register slave.
//
// Behaviour
// - Host sets each pin's direction individually.
// - Output pins drive host-latched levels until rewritten.
// - Optional primary debounce, 0 to 15 ms.
// - Optional secondary up/down filter, programmable sampling interval.
// - Processing applies only when enabled, else raw.
// - Demultiplex splits primary into off-hook and ground-key.
// - Demultiplexed ground key replaces secondary input.
// - Demultiplexed bits get debounce and filter too.
// - Channel read returns processed bits and aux levels.
// - Two bulk reads return all channels' bits.
// - Auxiliary input levels readable by channel read.
//
// Decided for this implementation: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
module lcio_top #(
  parameter int TICK_CYCLES = lcio_pkg::TICK_CYCLES_DEF  // Clock cycles per base time step.
) (
  input  wire logic                          hclk,                   // Bus clock, 250 MHz.
  input  wire logic                          hresetn,                // Asynchronous reset, active low.
  input  wire logic                          hce,                    // Clock enable for all state.
  input  wire logic                          hsel,                   // Slave select.
  input  wire logic [31:0]                   haddr,                  // Byte address.
  input  wire logic [1:0]                    htrans,                 // Transfer type.
  input  wire logic                          hwrite,                 // Write when high.
  input  wire logic [2:0]                    hsize,                  // Transfer size.
  input  wire logic [31:0]                   hwdata,                 // Write data.
  input  wire logic                          hready,                 // Bus ready.
  output logic                               hreadyout,              // Slave ready.
  output logic [31:0]                        hrdata,                 // Read data.
  output logic [1:0]                         hresp,                  // Always OKAY.
  input  wire logic [lcio_pkg::NCH-1:0]      line_input_primary_i,   // Primary pin levels.
  output logic      [lcio_pkg::NCH-1:0]      line_input_primary_o,   // Primary pin drive.
  output logic      [lcio_pkg::NCH-1:0]      line_input_primary_oe,  // Primary pin enable.
  input  wire logic [lcio_pkg::NCH-1:0]      line_input_secondary_i, // Secondary pin levels.
  output logic      [lcio_pkg::NCH-1:0]      line_input_secondary_o, // Secondary pin drive.
  output logic      [lcio_pkg::NCH-1:0]      line_input_secondary_oe,// Secondary pin enable.
  input  wire logic [lcio_pkg::NCH-1:0]      aux_io_three_i,         // Aux three levels.
  output logic      [lcio_pkg::NCH-1:0]      aux_io_three_o,         // Aux three drive.
  output logic      [lcio_pkg::NCH-1:0]      aux_io_three_oe,        // Aux three enable.
  input  wire logic [lcio_pkg::NCH-1:0]      aux_io_four_i,          // Aux four levels.
  output logic      [lcio_pkg::NCH-1:0]      aux_io_four_o,          // Aux four drive.
  output logic      [lcio_pkg::NCH-1:0]      aux_io_four_oe,         // Aux four enable.
  input  wire logic [lcio_pkg::NCH-1:0]      aux_io_five_i,          // Aux five levels.
  output logic      [lcio_pkg::NCH-1:0]      aux_io_five_o,          // Aux five drive.
  output logic      [lcio_pkg::NCH-1:0]      aux_io_five_oe,         // Aux five enable.
  output logic                               ground_key_demux_sel    // Demultiplex phase to the line circuits.
);
  import lcio_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  lcio_bus_t                    bus_q;        // Slave state.
  logic [ADDR_W-1:0]            addr_q;       // Captured address.
  logic                         hreadyout_q;  // Ready flop.
  logic [31:0]                  hrdata_q;     // Read data flop.
  logic [31:0]                  rd_mux;       // Read data selected by address.
  logic                         accept;       // Address phase taken.
  logic                         wr_fire;      // Write data phase completes.
  logic [NCH-1:0]               chan_en_q;    // Channel select bits.
  logic [NCH-1:0][NPIN-1:0]     dir_q;        // Directions, 1 = output.
  logic [NCH-1:0][NPIN-1:0]     out_q;        // Latched output levels.
  logic [NCH-1:0][TIME_W-1:0]   deb_q;        // Debounce times.
  logic [NCH-1:0][TIME_W-1:0]   samp_q;       // Sampling intervals.
  logic [NCH-1:0][PROC_W-1:0]   proc_q;       // Processing enables.
  logic [NCH-1:0][NPIN-1:0]     pin_in;       // Pin levels grouped per channel.
  logic [NCH-1:0]               offhook_q;    // Recovered off-hook level.
  logic [NCH-1:0]               gkey_q;       // Recovered ground-key level.
  logic [NCH-1:0]               pri_proc;     // Processed primary bits.
  logic [NCH-1:0]               sec_proc;     // Processed secondary bits.
  logic [TICK_W-1:0]            tick_cnt_q;   // Base time step counter.
  logic                         tick_q;       // Base time step pulse.
  logic                         gk_phase_q;   // Demultiplex phase.
  logic [1:0]                   rd_ch;        // Channel shown by reads.

  // Lowest-numbered selected channel answers channel reads.
  function automatic logic [1:0] first_chan(input logic [NCH-1:0] en);
    logic [1:0] idx;
    idx = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (en[i]) begin
        idx = i[1:0];
      end
    end
    return idx;
  endfunction

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  assign accept  = hsel && htrans[1] && hready;
  assign wr_fire = hce && (bus_q == LCIO_BUS_WRITE);

  // Writes finish with no wait; reads take one wait state so they see a preceding write.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_q       <= LCIO_BUS_IDLE;
      addr_q      <= '0;
      hreadyout_q <= 1'b1;
      hrdata_q    <= '0;
    end else if (hce) begin
      unique case (bus_q)
        // Idle or write data phase: a new address phase may be taken.
        LCIO_BUS_IDLE, LCIO_BUS_WRITE: begin
          if (accept) begin
            addr_q <= haddr[ADDR_W-1:0];
            if (hwrite) begin
              bus_q <= LCIO_BUS_WRITE;
            end else begin
              bus_q       <= LCIO_BUS_RDWAIT;
              hreadyout_q <= 1'b0;
            end
          end else begin
            bus_q <= LCIO_BUS_IDLE;
          end
        end
        // Read wait: ready is low, so no address phase is taken here.
        LCIO_BUS_RDWAIT: begin
          hrdata_q    <= rd_mux;
          hreadyout_q <= 1'b1;
          bus_q       <= LCIO_BUS_IDLE;
        end
        // The unused code falls back to idle with ready high.
        default: begin
          bus_q       <= LCIO_BUS_IDLE;
          hreadyout_q <= 1'b1;
        end
      endcase
    end
  end

  assign hreadyout = hreadyout_q;
  assign hrdata    = hrdata_q;
  assign hresp     = HRESP_OKAY;
  assign rd_ch     = first_chan(chan_en_q);

  // Read multiplexer; unmapped addresses, and per-channel registers while no channel is selected, read zero.
  always_comb begin
    rd_mux = '0;
    case (addr_q)
      OFS_CHAN_EN:  rd_mux[NCH-1:0]    = chan_en_q;
      OFS_DIR:      rd_mux[NPIN-1:0]   = (|chan_en_q) ? dir_q[rd_ch] : '0;
      OFS_OUT:      rd_mux[NPIN-1:0]   = (|chan_en_q) ? out_q[rd_ch] : '0;
      OFS_DEBOUNCE: rd_mux[TIME_W-1:0] = (|chan_en_q) ? deb_q[rd_ch] : '0;
      OFS_SAMPLE:   rd_mux[TIME_W-1:0] = (|chan_en_q) ? samp_q[rd_ch] : '0;
      OFS_PROC:     rd_mux[PROC_W-1:0] = (|chan_en_q) ? proc_q[rd_ch] : '0;
      OFS_CHAN_RD: begin
        if (|chan_en_q) begin
          rd_mux[NPIN-1:0] = pin_in[rd_ch];
          rd_mux[PIN_PRI]  = pri_proc[rd_ch];
          rd_mux[PIN_SEC]  = sec_proc[rd_ch];
        end
      end
      OFS_BULK_PRI: rd_mux[NCH-1:0]    = pri_proc;
      OFS_BULK_SEC: rd_mux[NCH-1:0]    = sec_proc;
      default:      rd_mux             = '0;
    endcase
  end

  // Channel enables gate every per-channel write below.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chan_en_q <= CHAN_EN_RST;
    end else if (wr_fire && addr_q == OFS_CHAN_EN) begin
      chan_en_q <= hwdata[NCH-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Time base and demultiplex phase
  // ----------------------------------------------------------------
  // One pulse per base step; the demultiplex phase alternates on each pulse.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
      gk_phase_q <= 1'b0;
    end else if (hce) begin
      tick_q <= 1'b0;
      if (tick_cnt_q == TICK_W'(TICK_CYCLES - 1)) begin
        tick_cnt_q <= '0;
        tick_q     <= 1'b1;
        gk_phase_q <= ~gk_phase_q;
      end else begin
        tick_cnt_q <= tick_cnt_q + TICK_W'(1);
      end
    end
  end

  assign ground_key_demux_sel = gk_phase_q;

  // ----------------------------------------------------------------
  // Per-channel logic
  // ----------------------------------------------------------------
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    lcio_filt_if fif ();

    assign pin_in[c] = {aux_io_five_i[c], aux_io_four_i[c], aux_io_three_i[c],
                        line_input_secondary_i[c], line_input_primary_i[c]};

    // Configuration is written to every selected channel at once.
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        dir_q[c]  <= DIR_RST;
        out_q[c]  <= OUT_RST;
        deb_q[c]  <= '0;
        samp_q[c] <= '0;
        proc_q[c] <= '0;
      end else if (wr_fire && chan_en_q[c]) begin
        case (addr_q)
          OFS_DIR:      dir_q[c]  <= hwdata[NPIN-1:0];
          OFS_OUT:      out_q[c]  <= hwdata[NPIN-1:0];
          OFS_DEBOUNCE: deb_q[c]  <= hwdata[TIME_W-1:0];
          OFS_SAMPLE:   samp_q[c] <= hwdata[TIME_W-1:0];
          OFS_PROC:     proc_q[c] <= hwdata[PROC_W-1:0];
          default:      dir_q[c]  <= dir_q[c];
        endcase
      end
    end

    // The primary pin carries off-hook in phase low and ground key in phase high.
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        offhook_q[c] <= 1'b0;
        gkey_q[c]    <= 1'b0;
      end else if (hce && tick_q) begin
        if (gk_phase_q) begin
          gkey_q[c] <= line_input_primary_i[c];
        end else begin
          offhook_q[c] <= line_input_primary_i[c];
        end
      end
    end

    // In demultiplex mode both recovered bits still pass through the filters.
    assign fif.tick     = tick_q;
    assign fif.deb_time = deb_q[c];
    assign fif.samp_int = samp_q[c];
    assign fif.deb_en   = proc_q[c][PROC_DEB];
    assign fif.filt_en  = proc_q[c][PROC_FILT];
    assign fif.raw_pri  = proc_q[c][PROC_DEMUX] ? offhook_q[c] : line_input_primary_i[c];
    assign fif.raw_sec  = proc_q[c][PROC_DEMUX] ? gkey_q[c] : line_input_secondary_i[c];
    assign pri_proc[c]  = fif.pri_out;
    assign sec_proc[c]  = fif.sec_out;

    lcio_chan_filt u_filt (
      .hclk    (hclk),
      .hresetn (hresetn),
      .hce     (hce),
      .f       (fif.filt)
    );

    // Output enables follow directions; levels come from the latches.
    assign line_input_primary_oe[c]   = dir_q[c][PIN_PRI];
    assign line_input_secondary_oe[c] = dir_q[c][PIN_SEC];
    assign aux_io_three_oe[c]         = dir_q[c][PIN_AUX3];
    assign aux_io_four_oe[c]          = dir_q[c][PIN_AUX4];
    assign aux_io_five_oe[c]          = dir_q[c][PIN_AUX5];
    assign line_input_primary_o[c]    = out_q[c][PIN_PRI];
    assign line_input_secondary_o[c]  = out_q[c][PIN_SEC];
    assign aux_io_three_o[c]          = out_q[c][PIN_AUX3];
    assign aux_io_four_o[c]           = out_q[c][PIN_AUX4];
    assign aux_io_five_o[c]           = out_q[c][PIN_AUX5];
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_read_taken;
    hce && accept && !hwrite;
  endsequence
  sequence s_read_answer;
    !hreadyout_q ##1 (hreadyout_q == $past(hce));
  endsequence

  a_read_wait: assert property (s_read_taken |=> s_read_answer)
    else $error("Read did not answer after one wait state.");
  a_dir_write: assert property (wr_fire && addr_q == OFS_DIR && chan_en_q[0]
                                |=> line_input_secondary_oe[0] == $past(hwdata[PIN_SEC]))
    else $error("Direction write did not reach the pin enable.");
  a_out_hold: assert property (!(wr_fire && addr_q == OFS_OUT) |=> $stable(out_q))
    else $error("Output latch changed without a write.");
  a_bulk_sec: assert property (hce && bus_q == LCIO_BUS_RDWAIT && addr_q == OFS_BULK_SEC
                               |=> hrdata[NCH-1:0] == $past(sec_proc))
    else $error("Bulk read lost the secondary bits.");
  a_gk_capture: assert property (hce && tick_q && gk_phase_q
                                 |=> gkey_q[0] == $past(line_input_primary_i[0]))
    else $error("Ground-key phase not captured.");
  a_bulk_pri: assert property (hce && bus_q == LCIO_BUS_RDWAIT && addr_q == OFS_BULK_PRI
                               |=> hrdata[NCH-1:0] == $past(pri_proc))
    else $error("Bulk read lost the primary bits.");
  // A low clock enable keeps latches, selection and the time base still.
  a_hce_freeze: assert property (!hce |=> $stable(out_q) && $stable(chan_en_q) && $stable(tick_cnt_q))
    else $error("State moved while the clock enable was low.");
  // An output latch write must leave channel 1 untouched while it is not selected.
  a_chan_gate: assert property (wr_fire && addr_q == OFS_OUT && !chan_en_q[1] |=> $stable(out_q[1]))
    else $error("Write reached an unselected channel.");

endmodule

/* File: src/lcio_pkg.sv */
// Shared constants and types for the line circuit I/O port block.
package lcio_pkg;

  // ----------------------------------------------------------------
  // Structure
  // ----------------------------------------------------------------
  localparam int NCH      = 4;   // Line channels.
  localparam int NPIN     = 5;   // Control pins per channel.
  localparam int PIN_PRI  = 0;   // Primary line input pin index.
  localparam int PIN_SEC  = 1;   // Secondary line input pin index.
  localparam int PIN_AUX3 = 2;   // Auxiliary pin three index.
  localparam int PIN_AUX4 = 3;   // Auxiliary pin four index.
  localparam int PIN_AUX5 = 4;   // Auxiliary pin five index.

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int         ADDR_W       = 8;      // Decoded address bits.
  localparam logic [7:0] OFS_CHAN_EN  = 8'h00;  // Channel enables.
  localparam logic [7:0] OFS_DIR      = 8'h04;  // Pin directions, 1 = output.
  localparam logic [7:0] OFS_OUT      = 8'h08;  // Latched output levels.
  localparam logic [7:0] OFS_DEBOUNCE = 8'h0C;  // Debounce time in ms.
  localparam logic [7:0] OFS_SAMPLE   = 8'h10;  // Filter sampling interval.
  localparam logic [7:0] OFS_PROC     = 8'h14;  // Processing enables.
  localparam logic [7:0] OFS_CHAN_RD  = 8'h18;  // Per-channel input read.
  localparam logic [7:0] OFS_BULK_PRI = 8'h1C;  // Primary bits, all channels.
  localparam logic [7:0] OFS_BULK_SEC = 8'h20;  // Secondary bits, all channels.

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int PROC_DEB   = 0;  // Debounce enable bit.
  localparam int PROC_FILT  = 1;  // Up/down filter enable bit.
  localparam int PROC_DEMUX = 2;  // Ground-key demultiplex enable bit.
  localparam int PROC_W     = 3;  // Processing field width.
  localparam int TIME_W     = 4;  // Debounce and sample field width.
  localparam int FILT_W     = 2;  // Up/down counter width.
  localparam logic [FILT_W-1:0] FILT_MAX    = 2'h3;   // Counter saturation.
  localparam logic [FILT_W-1:0] FILT_ONE    = 2'h1;   // Counter step.
  localparam logic [TIME_W-1:0] TIME_ONE    = 4'h1;   // Time step.
  localparam logic [3:0]        CHAN_EN_RST = 4'h0;   // No channel selected.
  localparam logic [4:0]        DIR_RST     = 5'h00;  // All pins inputs.
  localparam logic [4:0]        OUT_RST     = 5'h00;  // All latches low.
  localparam logic [1:0]        HRESP_OKAY  = 2'h0;   // AHB OKAY response.

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS   = 4000;           // Clock period, ps.
  localparam int TICK_TIME_MS    = 1;              // Base time step, ms.
  localparam int PS_PER_MS       = 1000000000;     // Picoseconds per ms.
  localparam int TICK_CYCLES_DEF = TICK_TIME_MS * PS_PER_MS / CLK_PERIOD_PS;
  localparam int TICK_W          = 18;             // Tick counter width.

  // Bus slave states.
  typedef enum logic [1:0] {
    LCIO_BUS_IDLE   = 2'b00,
    LCIO_BUS_WRITE  = 2'b01,
    LCIO_BUS_RDWAIT = 2'b10
  } lcio_bus_t;

endpackage

/* File: src/lcio_filt_if.sv */
// Interface between the port controller and one channel's input filter.
`timescale 1ns/10ps
interface lcio_filt_if;
  logic       tick;      // One-cycle pulse every base time step.
  logic [3:0] deb_time;  // Debounce time in steps.
  logic [3:0] samp_int;  // Sampling interval in steps.
  logic       deb_en;    // Debounce enable.
  logic       filt_en;   // Up/down filter enable.
  logic       raw_pri;   // Unprocessed primary level.
  logic       raw_sec;   // Unprocessed secondary level.
  logic       pri_out;   // Processed primary bit.
  logic       sec_out;   // Processed secondary bit.
  modport ctrl (output tick, deb_time, samp_int, deb_en, filt_en, raw_pri, raw_sec,
                input pri_out, sec_out);
  modport filt (input tick, deb_time, samp_int, deb_en, filt_en, raw_pri, raw_sec,
                output pri_out, sec_out);
endinterface

/* File: src/lcio_chan_filt.sv */
// Debounce and up/down counter filter for one line channel.
`timescale 1ns/10ps
module lcio_chan_filt (
  input wire logic hclk,    // Bus clock.
  input wire logic hresetn, // Asynchronous reset, active low.
  input wire logic hce,     // Clock enable, freezes state when low.
  lcio_filt_if.filt f       // Filter configuration and data.
);
  import lcio_pkg::*;

  logic [TIME_W-1:0] deb_cnt_q;   // Steps the new primary level has held.
  logic              stable_q;    // Debounced primary level.
  logic [TIME_W-1:0] samp_cnt_q;  // Steps since last filter sample.
  logic [FILT_W-1:0] ud_q;        // Up/down counter.
  logic              filt_q;      // Filtered secondary level.
  logic              pri_q;       // Presented primary bit.
  logic              sec_q;       // Presented secondary bit.

  // ----------------------------------------------------------------
  // Debounce
  // ----------------------------------------------------------------
  // A new level is accepted only after it held for the full time; any return to the old level restarts it.
  // The first step after a change may be partial, so one step more than the setting is counted.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      deb_cnt_q <= '0;
      stable_q  <= 1'b0;
    end else if (hce) begin
      if (f.raw_pri == stable_q) begin
        deb_cnt_q <= '0;                                // Level agrees, nothing pending.
      end else if (f.deb_time == '0) begin
        stable_q  <= f.raw_pri;
        deb_cnt_q <= '0;
      end else if (f.tick) begin
        if (deb_cnt_q >= f.deb_time) begin
          stable_q  <= f.raw_pri;
          deb_cnt_q <= '0;
        end else begin
          deb_cnt_q <= deb_cnt_q + TIME_ONE;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Up/down counter filter
  // ----------------------------------------------------------------
  // Samples the secondary level once per interval and walks the counter toward it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      samp_cnt_q <= '0;
      ud_q       <= '0;
    end else if (hce && f.tick) begin
      if (samp_cnt_q >= f.samp_int) begin
        samp_cnt_q <= '0;
        if (f.raw_sec && ud_q != FILT_MAX) begin
          ud_q <= ud_q + FILT_ONE;
        end else if (!f.raw_sec && ud_q != '0) begin
          ud_q <= ud_q - FILT_ONE;
        end
      end else begin
        samp_cnt_q <= samp_cnt_q + TIME_ONE;
      end
    end
  end

  // The filtered level flips only at the counter's ends, giving hysteresis.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      filt_q <= 1'b0;
    end else if (hce) begin
      if (ud_q == FILT_MAX) begin
        filt_q <= 1'b1;
      end else if (ud_q == '0) begin
        filt_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Presented bits
  // ----------------------------------------------------------------
  // Raw levels pass unless processing is enabled.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pri_q <= 1'b0;
      sec_q <= 1'b0;
    end else if (hce) begin
      pri_q <= f.deb_en ? stable_q : f.raw_pri;
      sec_q <= f.filt_en ? filt_q : f.raw_sec;
    end
  end

  assign f.pri_out = pri_q;
  assign f.sec_out = sec_q;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_deb_bypass: assert property (hce && !f.deb_en |=> f.pri_out == $past(f.raw_pri))
    else $error("Primary bit not raw while debounce is off.");
  a_deb_direct: assert property (hce && f.deb_time == '0 |=> stable_q == $past(f.raw_pri))
    else $error("Zero debounce time did not pass the level.");
  a_deb_hold: assert property (hce && f.deb_time != '0 && !f.tick |=> $stable(stable_q))
    else $error("Debounced level changed between time steps.");
  a_filt_bypass: assert property (hce && !f.filt_en |=> f.sec_out == $past(f.raw_sec))
    else $error("Secondary bit not raw while filter is off.");
  a_filt_top: assert property (hce && ud_q == FILT_MAX |=> filt_q)
    else $error("Saturated counter did not raise the filtered level.");

endmodule

/* File: verif/lcio_line_model.sv */
// Model of the line circuits that sit on the control pins.
`timescale 1ns/10ps
module lcio_line_model (
  input  wire logic        sel,  // Demultiplex phase, 1 = ground key.
  input  wire logic        mux,  // Line circuits multiplex the primary pin.
  input  wire logic [19:0] drv,  // Line-side levels, five groups of four.
  input  wire logic [3:0]  gk,   // Ground key levels.
  input  wire logic [19:0] o,    // Device drive levels.
  input  wire logic [19:0] oe,   // Device drive enables.
  output logic      [19:0] pin   // Resolved pin levels.
);
  logic [19:0] src;  // Level that the line side offers.
  // The primary pin carries hook or ground key by phase when multiplexing.
  assign src = (mux && sel) ? {drv[19:4], gk} : drv;
  // A driven pin shows the device level, otherwise the line level.
  assign pin = (oe & o) | (~oe & src);
endmodule

/* File: verif/tb_top.sv */
// Self-checking bench for the line circuit I/O ports.
`timescale 1ns/10ps
module tb_top;
  import lcio_pkg::*;
  logic        hclk = 0;                       // Bus clock.
  logic        hresetn = 0;                    // Reset, active low.
  logic        hce = 1;                        // Clock enable.
  logic        hwrite = 0;                     // Write when high.
  logic        mux = 0;                        // Line circuits multiplex.
  logic [1:0]  htrans = 0;                     // Transfer type.
  logic [31:0] haddr = 0, hwdata = 0, hrdata;  // Bus address and data.
  logic [19:0] drv = 0;                        // Line-side levels, primary lowest.
  wire  [19:0] o, oe, pin;                     // Pin groups, primary lowest.
  logic [1:0]  resp;                           // Bus response.
  logic [3:0]  gk = 0;                         // Ground key levels.
  logic        rdy, sel;                       // Ready, demultiplex phase.
  int          n_fail = 0, n_compared = 0;     // Verdict counters.
  initial forever #2 hclk = ~hclk;
  lcio_top #(.TICK_CYCLES(8)) lcio_top_i (.hclk, .hresetn, .hce, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(rdy), .hreadyout(rdy), .hrdata, .hresp(resp),
    .line_input_primary_i(pin[3:0]), .line_input_primary_o(o[3:0]), .line_input_primary_oe(oe[3:0]),
    .line_input_secondary_i(pin[7:4]), .line_input_secondary_o(o[7:4]), .line_input_secondary_oe(oe[7:4]),
    .aux_io_three_i(pin[11:8]), .aux_io_three_o(o[11:8]), .aux_io_three_oe(oe[11:8]),
    .aux_io_four_i(pin[15:12]), .aux_io_four_o(o[15:12]), .aux_io_four_oe(oe[15:12]),
    .aux_io_five_i(pin[19:16]), .aux_io_five_o(o[19:16]), .aux_io_five_oe(oe[19:16]),
    .ground_key_demux_sel(sel));
  lcio_line_model lcio_line_model_i (.sel, .mux, .drv, .gk, .o, .oe, .pin);
  // Prints the counts and the verdict, then stops.
  task automatic complete_run;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // Waits a bounded number of edges for the slave ready.
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (rdy !== 1'b1 && k < 40);
    if (rdy !== 1'b1) begin
      n_fail++;
      complete_run;
    end
  endtask
  // One single word transfer: address phase, then data phase.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), hrdata, e);
    chk("hresp", resp, 32'h0);
  endtask
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("enables", oe, 20'h0);
    xfer(1'b1, OFS_CHAN_EN, 32'h1);
    xfer(1'b1, OFS_DIR, 32'h18);
    xfer(1'b1, OFS_OUT, 32'h14);
    xfer(1'b1, OFS_PROC, 32'h0);
    drv <= 20'h00101;
    repeat (2) @(posedge hclk);
    chk("enables", oe, 20'h11000);
    chk("levels", o, 20'h10100);
    rd(OFS_CHAN_RD, 32'h15);
    drv <= 20'h0015A;
    repeat (2) @(posedge hclk);
    rd(OFS_BULK_PRI, 32'hA);
    rd(OFS_BULK_SEC, 32'h5);
    xfer(1'b1, OFS_CHAN_EN, 32'hF);
    xfer(1'b1, OFS_DEBOUNCE, 32'h2);
    xfer(1'b1, OFS_PROC, 32'h1);
    drv <= 20'h0;
    repeat (40) @(posedge hclk);
    drv <= 20'h0000F;
    rd(OFS_BULK_PRI, 32'h0);
    repeat (40) @(posedge hclk);
    rd(OFS_BULK_PRI, 32'hF);
    xfer(1'b1, OFS_SAMPLE, 32'h0);
    xfer(1'b1, OFS_PROC, 32'h2);
    drv <= 20'h000F0;
    rd(OFS_BULK_SEC, 32'h0);
    repeat (60) @(posedge hclk);
    rd(OFS_BULK_SEC, 32'hF);
    rd(OFS_BULK_PRI, 32'h0);
    hce <= 1'b0;
    repeat (12) @(posedge hclk);
    hce <= 1'b1;
    xfer(1'b1, OFS_PROC, 32'h4);
    mux <= 1'b1;
    gk <= 4'h6;
    drv <= 20'h00093;
    repeat (60) @(posedge hclk);
    rd(OFS_BULK_PRI, 32'h3);
    rd(OFS_BULK_SEC, 32'h6);
    xfer(1'b1, OFS_PROC, 32'h7);
    gk <= 4'h9;
    drv <= 20'h0000C;
    rd(OFS_BULK_PRI, 32'h3);
    repeat (80) @(posedge hclk);
    rd(OFS_BULK_PRI, 32'hC);
    rd(OFS_BULK_SEC, 32'h9);
    xfer(1'b1, OFS_DIR, 32'h2);
    @(posedge hclk);
    chk("enables", oe, 20'h000F0);
    complete_run;
  end
endmodule
